// ===== common/asp_pkg.sv
// Constants for the scan, pacer and sample buffer sequencer
package asp_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_CHAN = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_PACE = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_GAIN = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_STAT = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_IEN = 12'h014;
   localparam logic [ADDR_W-1:0] OFF_FIFO = 12'h018;
   localparam logic [ADDR_W-1:0] OFF_DOUT = 12'h01c;
   localparam logic [ADDR_W-1:0] OFF_EXPS = 12'h020;
   // Control fields
   localparam int C_START = 0;
   localparam int C_DIFF = 1;
   localparam int C_BIPOLAR = 2;
   localparam int C_SCAN = 3;
   localparam int C_EXTPACE = 4;
   localparam int C_HWTRIG = 5;
   localparam int C_FAST = 6;
   localparam int C_EXPAND = 7;
   localparam int C_SWCONV = 8;
   // Event bits in status and enable
   localparam int EV_READY = 0;
   localparam int EV_HALF = 1;
   localparam int EV_CLKERR = 2;
   localparam int EV_OVR = 3;
   localparam int NUM_EV = 4;
   localparam int SE_CHANS = 16;
   localparam int DIFF_CHANS = 8;
   localparam int EXP_UNITS = 16;
   localparam int FIFO_DEPTH = 512;
   localparam int HALF_LEVEL = 256;
   localparam int SAMPLE_W = 12;
   localparam int GAIN_W = 2;
   // Time base
   localparam int CLK_MHZ = 100;
   localparam int BASE_SLOW_MHZ = 1;
   localparam int BASE_FAST_MHZ = 10;
   localparam int DIV_SLOW = CLK_MHZ / BASE_SLOW_MHZ;
   localparam int DIV_FAST = CLK_MHZ / BASE_FAST_MHZ;
   // Conversion busy time, nanoseconds and cycles
   localparam int CONV_NS = 7000;
   localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int MUX_ADV_CYC = 2;
   localparam logic [31:0] RESP_DEFAULT = 32'h0000_0000;
   typedef enum logic [1:0]
   {
      ASP_IDLE = 2'b00,
      ASP_WAIT_TRIG = 2'b01,
      ASP_RUN = 2'b10
   } asp_state_t;
endpackage : asp_pkg

// ===== core/asp_sequencer.sv
// Scan sequencer, pacer, sample buffer and APB register slave
`timescale 1ns/1ps
module asp_sequencer #(
   parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH,
   parameter int CONV_CYC = asp_pkg::CONV_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [asp_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_pacer_in,
   input wire logic ext_trigger_in,
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [asp_pkg::SAMPLE_W-1:0] conv_data,
   output logic [3:0] mux_addr,
   output logic diff_mode,
   output logic bipolar,
   output logic [asp_pkg::GAIN_W-1:0] gain_sel,
   output logic [3:0] expansion_select_out,
   output logic [3:0] gp_out,
   output logic irq
);
   localparam int LW = $clog2(FIFO_DEPTH + 1);
   localparam int PW = $clog2(FIFO_DEPTH);
   localparam int CW = $clog2(CONV_CYC + 1);

   // Software registers
   logic [8:0] ctrl, next_ctrl;
   logic [7:0] start_ch, next_start_ch, stop_ch, next_stop_ch;
   logic [15:0] pace, next_pace;
   logic [3:0] ien, next_ien;
   logic [3:0] dout, next_dout;
   logic [2*asp_pkg::SE_CHANS-1:0] gains, next_gains;
   logic clk_err, next_clk_err, ovr, next_ovr;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   // Sequencer state
   asp_pkg::asp_state_t state, next_state;
   logic [7:0] chan, next_chan;
   logic [15:0] cnt, next_cnt;
   logic [6:0] div, next_div;
   logic [CW-1:0] busy, next_busy;
   logic [1:0] adv, next_adv;
   logic pace_d, next_pace_d, trig_d, next_trig_d;
   // Sample buffer
   logic [asp_pkg::SAMPLE_W-1:0] mem [FIFO_DEPTH];
   logic [PW-1:0] wp, next_wp, rp, next_rp;
   logic [LW-1:0] level, next_level;
   logic [3:0] next_exp;
   logic next_irq, next_conv_start;

   logic setup_w, access, rd_fifo, wr_fifo, pulse, tick, run_pacing;
   logic [7:0] top_ch;
   logic [3:0] events;

   assign access = psel && penable && pready;
   // Writes land at the edge that ends the access phase
   assign setup_w = access && pwrite;
   assign rd_fifo = psel && !penable && !pwrite && paddr == asp_pkg::OFF_FIFO
      && level != '0;
   assign top_ch = ctrl[asp_pkg::C_EXPAND] ? 8'hff
      : (ctrl[asp_pkg::C_DIFF] ? 8'h07 : 8'h0f);
   assign tick = (div == 7'h00);
   assign run_pacing = (state == asp_pkg::ASP_RUN) && ctrl[asp_pkg::C_SCAN];
   // Ext pacer is sampled as synchronous; falling edge detect
   assign pulse = run_pacing && (ctrl[asp_pkg::C_EXTPACE] ? (pace_d && !ext_pacer_in)
      : (tick && cnt == 16'h0000));
   assign wr_fifo = conv_done && level != LW'(FIFO_DEPTH);
   assign events = {ovr, clk_err, level >= LW'(asp_pkg::HALF_LEVEL), level != '0};

   always_comb
   begin
      next_ctrl = ctrl;
      next_start_ch = start_ch;
      next_stop_ch = stop_ch;
      next_pace = pace;
      next_ien = ien;
      next_dout = dout;
      next_gains = gains;
      next_clk_err = clk_err;
      next_ovr = ovr;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      next_pready = psel && !penable;
      next_ctrl[asp_pkg::C_SWCONV] = 1'b0;
      if (setup_w)
      begin
         if (paddr == asp_pkg::OFF_CTRL)
         begin
            next_ctrl = pwdata[8:0];
            // Strobe is set below only when scan is off
            next_ctrl[asp_pkg::C_SWCONV] = 1'b0;
            // Expansion is refused in differential mode
            if (pwdata[asp_pkg::C_DIFF])
               next_ctrl[asp_pkg::C_EXPAND] = 1'b0;
         end
         else if (paddr == asp_pkg::OFF_CHAN)
         begin
            next_start_ch = pwdata[7:0];
            next_stop_ch = pwdata[15:8];
         end
         else if (paddr == asp_pkg::OFF_PACE)
            next_pace = pwdata[15:0];
         else if (paddr == asp_pkg::OFF_GAIN)
            next_gains = pwdata;
         else if (paddr == asp_pkg::OFF_IEN)
            next_ien = pwdata[3:0];
         else if (paddr == asp_pkg::OFF_DOUT)
            next_dout = pwdata[3:0];
         else if (paddr == asp_pkg::OFF_STAT)
         begin
            // Write one to clear sticky errors
            if (pwdata[asp_pkg::EV_CLKERR])
               next_clk_err = 1'b0;
            if (pwdata[asp_pkg::EV_OVR])
               next_ovr = 1'b0;
         end
      end
      else if (psel && !penable && !pwrite)
      begin
         if (paddr == asp_pkg::OFF_CTRL)
            next_prdata = {23'h0, ctrl};
         else if (paddr == asp_pkg::OFF_CHAN)
            next_prdata = {8'h0, chan, stop_ch, start_ch};
         else if (paddr == asp_pkg::OFF_PACE)
            next_prdata = {16'h0, pace};
         else if (paddr == asp_pkg::OFF_GAIN)
            next_prdata = gains;
         else if (paddr == asp_pkg::OFF_STAT)
            next_prdata = {16'h0, 10'(level), 2'(state), events};
         else if (paddr == asp_pkg::OFF_IEN)
            next_prdata = {28'h0, ien};
         else if (paddr == asp_pkg::OFF_FIFO)
            next_prdata = {20'h0, (level != '0) ? mem[rp] : 12'h000};
         else if (paddr == asp_pkg::OFF_DOUT)
            next_prdata = {28'h0, dout};
         else
         begin
            next_prdata = asp_pkg::RESP_DEFAULT;
            next_pslverr = 1'b1;
         end
      end
      else if (psel && !penable)
      begin
         // Write target checked in setup so the error stands with pready
         if (paddr != asp_pkg::OFF_CTRL && paddr != asp_pkg::OFF_CHAN
            && paddr != asp_pkg::OFF_PACE && paddr != asp_pkg::OFF_GAIN
            && paddr != asp_pkg::OFF_STAT && paddr != asp_pkg::OFF_IEN
            && paddr != asp_pkg::OFF_DOUT)
            next_pslverr = 1'b1;
      end
      // Set wins over clear
      if (pulse && busy != '0)
         next_clk_err = 1'b1;
      if (conv_done && level == LW'(FIFO_DEPTH))
         next_ovr = 1'b1;
      if (setup_w && paddr == asp_pkg::OFF_CTRL && pwdata[asp_pkg::C_SWCONV]
         && !pwdata[asp_pkg::C_SCAN])
         next_ctrl[asp_pkg::C_SWCONV] = 1'b1;
   end

   always_comb
   begin
      next_state = state;
      next_chan = chan;
      next_cnt = cnt;
      next_div = div;
      next_busy = busy;
      next_adv = adv;
      next_pace_d = ext_pacer_in;
      next_trig_d = ext_trigger_in;
      next_conv_start = 1'b0;
      case (state)
         asp_pkg::ASP_IDLE:
         begin
            next_chan = ctrl[asp_pkg::C_SCAN] ? start_ch : start_ch & top_ch;
            if (ctrl[asp_pkg::C_START])
            begin
               next_cnt = pace - 16'd1;
               next_div = '0;
               next_state = ctrl[asp_pkg::C_HWTRIG] ? asp_pkg::ASP_WAIT_TRIG
                  : asp_pkg::ASP_RUN;
            end
         end
         asp_pkg::ASP_WAIT_TRIG:
         begin
            if (!ctrl[asp_pkg::C_START])
               next_state = asp_pkg::ASP_IDLE;
            else if (trig_d && !ext_trigger_in)
               next_state = asp_pkg::ASP_RUN;
         end
         asp_pkg::ASP_RUN:
         begin
            if (!ctrl[asp_pkg::C_START])
               next_state = asp_pkg::ASP_IDLE;
         end
         default:
            next_state = asp_pkg::ASP_IDLE;
      endcase
      // Time base divider: 1 or 10 MHz enable
      if (state == asp_pkg::ASP_RUN)
      begin
         if (tick)
            next_div = ctrl[asp_pkg::C_FAST] ? 7'(asp_pkg::DIV_FAST - 1)
               : 7'(asp_pkg::DIV_SLOW - 1);
         else
            next_div = div - 7'd1;
         // Reload one below the count so N counts span N ticks; 0 wraps to 65,536
         if (tick)
            next_cnt = (cnt == 16'h0000) ? pace - 16'd1 : cnt - 16'd1;
      end
      if (busy != '0)
         next_busy = busy - CW'(1);
      if ((pulse || ctrl[asp_pkg::C_SWCONV]) && busy == '0)
      begin
         next_conv_start = 1'b1;
         next_busy = CW'(CONV_CYC);
         next_adv = ctrl[asp_pkg::C_SCAN] ? 2'(asp_pkg::MUX_ADV_CYC) : 2'd0;
      end
      else if (adv != 2'd0)
      begin
         next_adv = adv - 2'd1;
         if (adv == 2'd1)
         begin
            if (chan == stop_ch)
               next_chan = start_ch;
            else if (chan == top_ch)
               next_chan = 8'h00;
            else
               next_chan = chan + 8'd1;
         end
      end
      next_exp = ctrl[asp_pkg::C_EXPAND] ? next_chan[7:4] : 4'h0;
   end

   always_comb
   begin
      // Pointers wrap at the depth, which need not be a power of two
      next_wp = wr_fifo ? ((wp == PW'(FIFO_DEPTH - 1)) ? '0 : wp + PW'(1)) : wp;
      next_rp = rd_fifo ? ((rp == PW'(FIFO_DEPTH - 1)) ? '0 : rp + PW'(1)) : rp;
      next_level = LW'(level + LW'(wr_fifo) - LW'(rd_fifo));
      next_irq = |(events & ien);
   end

   always_ff @(posedge pclk)
   begin
      if (wr_fifo)
         mem[wp] <= conv_data;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= '0;
         start_ch <= '0;
         stop_ch <= '0;
         pace <= '0;
         ien <= '0;
         dout <= '0;
         gains <= '0;
         clk_err <= 1'b0;
         ovr <= 1'b0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         state <= asp_pkg::ASP_IDLE;
         chan <= '0;
         cnt <= '0;
         div <= '0;
         busy <= '0;
         adv <= '0;
         pace_d <= 1'b1;
         trig_d <= 1'b1;
         wp <= '0;
         rp <= '0;
         level <= '0;
         irq <= 1'b0;
         conv_start <= 1'b0;
         mux_addr <= '0;
         diff_mode <= 1'b0;
         bipolar <= 1'b0;
         gain_sel <= '0;
         expansion_select_out <= '0;
         gp_out <= '0;
      end
      else
      begin
         ctrl <= next_ctrl;
         start_ch <= next_start_ch;
         stop_ch <= next_stop_ch;
         pace <= next_pace;
         ien <= next_ien;
         dout <= next_dout;
         gains <= next_gains;
         clk_err <= next_clk_err;
         ovr <= next_ovr;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         state <= next_state;
         chan <= next_chan;
         cnt <= next_cnt;
         div <= next_div;
         busy <= next_busy;
         adv <= next_adv;
         pace_d <= next_pace_d;
         trig_d <= next_trig_d;
         wp <= next_wp;
         rp <= next_rp;
         level <= next_level;
         irq <= next_irq;
         conv_start <= next_conv_start;
         mux_addr <= next_chan[3:0];
         diff_mode <= ctrl[asp_pkg::C_DIFF];
         bipolar <= ctrl[asp_pkg::C_BIPOLAR];
         // Scan takes channel-0 gain for all; per-channel gain only in single mode
         gain_sel <= ctrl[asp_pkg::C_SCAN] ? gains[1:0]
            : gains[2*next_chan[3:0] +: 2];
         expansion_select_out <= next_exp;
         gp_out <= ctrl[asp_pkg::C_EXPAND] ? 4'h0 : dout;
      end
   end

   sequence s_fire;
      pulse && busy == '0;
   endsequence

   a_conv_fires: assert property (@(posedge pclk) disable iff (!presetn)
      s_fire |=> conv_start) else $error("conversion not started on pacer pulse");
   a_clk_error: assert property (@(posedge pclk) disable iff (!presetn)
      pulse && busy != '0 |=> clk_err) else $error("clock error missed");
   a_overrun_flag: assert property (@(posedge pclk) disable iff (!presetn)
      conv_done && level == LW'(FIFO_DEPTH)
      |=> ovr && level == $past(level) - LW'($past(rd_fifo)))
      else $error("overrun not flagged");
   a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq == |($past(events) & $past(ien))) else $error("interrupt gating wrong");
   a_level_track: assert property (@(posedge pclk) disable iff (!presetn)
      wr_fifo && !rd_fifo |=> level == $past(level) + LW'(1))
      else $error("write did not raise level");
   a_read_pops: assert property (@(posedge pclk) disable iff (!presetn)
      rd_fifo && !wr_fifo |=> level == $past(level) - LW'(1))
      else $error("read did not remove word");
   a_scan_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      adv == 2'd1 && !(pulse && busy == '0) && chan == stop_ch |=> chan == $past(start_ch))
      else $error("scan did not return to start");
   a_idle_count: assert property (@(posedge pclk) disable iff (!presetn)
      state == asp_pkg::ASP_IDLE |-> !pulse) else $error("pacer ran while idle");
   a_trig_wait: assert property (@(posedge pclk) disable iff (!presetn)
      state == asp_pkg::ASP_WAIT_TRIG && !(trig_d && !ext_trigger_in) && ctrl[0]
      |=> state == asp_pkg::ASP_WAIT_TRIG) else $error("left trigger wait early");
endmodule : asp_sequencer

// ===== sim/asp_conv_model.sv
// Converter model: answers each conversion start that arrives while idle with a tagged sample
`timescale 1ns/1ps
module asp_conv_model #(
   parameter int LAT = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic conv_start,
   input wire logic [3:0] mux_addr,
   input wire logic [7:0] extra,
   output logic conv_done,
   output logic [11:0] conv_data
);
   int cnt;
   logic [7:0] seq;
   logic [3:0] ch;
   // Data line toggles when not valid so stale values never pass
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 0;
         seq <= 8'h00;
         ch <= 4'h0;
         conv_done <= 1'b0;
         conv_data <= 12'h000;
      end
      else
      begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start && cnt == 0)
         begin
            ch <= mux_addr;
            cnt <= LAT + int'(extra);
         end
         else if (cnt == 1)
         begin
            cnt <= 0;
            conv_done <= 1'b1;
            conv_data <= {seq, ch};
            seq <= seq + 8'h01;
         end
         else if (cnt != 0)
            cnt <= cnt - 1;
      end
   end
endmodule : asp_conv_model

// ===== sim/tb_adc_scan_pacer_sequencer.sv
// Self-checking bench for the scan, pacer and sample buffer sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_adc_scan_pacer_sequencer;
   localparam int DEPTH = 300;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [asp_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic ext_pacer_in, ext_trigger_in, conv_start, conv_done, diff_mode, bipolar, irq, seen;
   logic [asp_pkg::SAMPLE_W-1:0] conv_data;
   logic [3:0] mux_addr, expansion_select_out, gp_out;
   logic [asp_pkg::GAIN_W-1:0] gain_sel;
   logic [7:0] extra;
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   asp_sequencer #(.FIFO_DEPTH(DEPTH), .CONV_CYC(20)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pacer_in(ext_pacer_in),
      .ext_trigger_in(ext_trigger_in), .conv_start(conv_start), .conv_done(conv_done),
      .conv_data(conv_data), .mux_addr(mux_addr), .diff_mode(diff_mode), .bipolar(bipolar),
      .gain_sel(gain_sel), .expansion_select_out(expansion_select_out), .gp_out(gp_out),
      .irq(irq));
   asp_conv_model #(.LAT(12)) conv (.clk(pclk), .rst_n(presetn), .conv_start(conv_start),
      .mux_addr(mux_addr), .extra(extra), .conv_done(conv_done), .conv_data(conv_data));
   function automatic logic [31:0] cb(input int b);
      cb = 32'h1 << b;
   endfunction : cb
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rv, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] rv;
      logic er;
      apb(1'b1, a, wd, rv, er);
   endtask : wr
   task automatic rdr(input logic [11:0] a, output logic [31:0] rv);
      logic er;
      apb(1'b0, a, 32'h0, rv, er);
   endtask : rdr
   // Stop and let any conversion in flight land before draining
   task automatic stop_drain();
      logic [31:0] s;
      int k;
      wr(asp_pkg::OFF_CTRL, 32'h0);
      repeat (60) @(posedge pclk);
      rdr(asp_pkg::OFF_STAT, s);
      for (k = 0; k < 600 && s[15:6] != 10'h000; k++)
      begin
         rdr(asp_pkg::OFF_FIFO, s);
         rdr(asp_pkg::OFF_STAT, s);
      end
   endtask : stop_drain
   task automatic wait_level(input int lv);
      logic [31:0] s;
      int k;
      k = 0;
      do begin rdr(asp_pkg::OFF_STAT, s); k++; end while (int'(s[15:6]) < lv && k < 2000);
   endtask : wait_level
   task automatic gap(output int g);
      int k;
      k = 0;
      while (conv_start !== 1'b1 && k < 3000) begin @(posedge pclk); k++; end
      g = 0;
      do begin @(posedge pclk); g++; end while (conv_start !== 1'b1 && g < 3000);
   endtask : gap
   task automatic pace_edge(output logic s);
      s = 1'b0;
      @(posedge pclk);
      ext_pacer_in <= 1'b0;
      repeat (6)
      begin
         @(posedge pclk);
         if (conv_start === 1'b1) s = 1'b1;
      end
      ext_pacer_in <= 1'b1;
      repeat (6)
      begin
         @(posedge pclk);
         if (conv_start === 1'b1) s = 1'b1;
      end
   endtask : pace_edge
   task automatic t_reset();
      logic [31:0] rv;
      logic er;
      rdr(asp_pkg::OFF_IEN, d);
      `CHK(d, 32'h0)
      `CHK(irq, 1'b0)
      apb(1'b0, 12'h100, 32'h0, rv, er);
      `CHK(er, 1'b1)
      `CHK(rv, 32'h0)
   endtask : t_reset
   task automatic t_single();
      wr(asp_pkg::OFF_CHAN, 32'h0000_0005);
      wr(asp_pkg::OFF_CTRL, cb(asp_pkg::C_SWCONV));
      repeat (60) @(posedge pclk);
      rdr(asp_pkg::OFF_STAT, d);
      `CHK(d[asp_pkg::EV_READY], 1'b1)
      rdr(asp_pkg::OFF_FIFO, d);
      `CHK(d[3:0], 4'h5)
      rdr(asp_pkg::OFF_STAT, d);
      `CHK(d[asp_pkg::EV_READY], 1'b0)
   endtask : t_single
   task automatic t_scan_wrap();
      logic [3:0] exp_ch[5] = '{4'h7, 4'h0, 4'h1, 4'h2, 4'h7};
      wr(asp_pkg::OFF_GAIN, 32'h0000_000e);
      wr(asp_pkg::OFF_CHAN, 32'h0000_0207);
      wr(asp_pkg::OFF_PACE, 32'h0000_0005);
      wr(asp_pkg::OFF_CTRL, cb(0) | cb(asp_pkg::C_DIFF) | cb(asp_pkg::C_BIPOLAR)
         | cb(asp_pkg::C_SCAN) | cb(asp_pkg::C_FAST));
      wait_level(5);
      `CHK(diff_mode, 1'b1)
      `CHK(bipolar, 1'b1)
      `CHK(gain_sel, 2'b10)
      wr(asp_pkg::OFF_CTRL, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         rdr(asp_pkg::OFF_FIFO, d);
         `CHK(d[3:0], exp_ch[i])
      end
      stop_drain();
   endtask : t_scan_wrap
   task automatic t_pace();
      wr(asp_pkg::OFF_CHAN, 32'h0000_0000);
      wr(asp_pkg::OFF_PACE, 32'h0000_0004);
      wr(asp_pkg::OFF_CTRL, cb(0) | cb(asp_pkg::C_SCAN) | cb(asp_pkg::C_FAST));
      gap(n);
      gap(n);
      `CHK(n, 4 * asp_pkg::DIV_FAST)
      stop_drain();
      wr(asp_pkg::OFF_PACE, 32'h0000_0001);
      wr(asp_pkg::OFF_CTRL, cb(0) | cb(asp_pkg::C_SCAN));
      gap(n);
      gap(n);
      `CHK(n, asp_pkg::DIV_SLOW)
      stop_drain();
      // One fast count is shorter than a conversion
      wr(asp_pkg::OFF_CTRL, cb(0) | cb(asp_pkg::C_SCAN) | cb(asp_pkg::C_FAST));
      repeat (100) @(posedge pclk);
      rdr(asp_pkg::OFF_STAT, d);
      `CHK(d[asp_pkg::EV_CLKERR], 1'b1)
      stop_drain();
      wr(asp_pkg::OFF_STAT, cb(asp_pkg::EV_CLKERR));
   endtask : t_pace
   task automatic t_ext_trig();
      extra = 8'h04;
      wr(asp_pkg::OFF_CTRL, cb(0) | cb(asp_pkg::C_SCAN) | cb(asp_pkg::C_EXTPACE)
         | cb(asp_pkg::C_HWTRIG));
      pace_edge(seen);
      `CHK(seen, 1'b0)
      @(posedge pclk);
      ext_trigger_in <= 1'b0;
      repeat (4) @(posedge pclk);
      ext_trigger_in <= 1'b1;
      repeat (2)
      begin
         pace_edge(seen);
         `CHK(seen, 1'b1)
         repeat (30) @(posedge pclk);
      end
      pace_edge(seen);
      pace_edge(seen);
      rdr(asp_pkg::OFF_STAT, d);
      `CHK(d[asp_pkg::EV_CLKERR], 1'b1)
      wr(asp_pkg::OFF_STAT, cb(asp_pkg::EV_CLKERR));
      rdr(asp_pkg::OFF_STAT, d);
      `CHK(d[asp_pkg::EV_CLKERR], 1'b0)
      stop_drain();
      extra = 8'h00;
   endtask : t_ext_trig
   task automatic t_fill();
      logic [7:0] sq;
      int k;
      wr(asp_pkg::OFF_CHAN, 32'h0000_0303);
      wr(asp_pkg::OFF_PACE, 32'h0000_0003);
      wr(asp_pkg::OFF_IEN, cb(asp_pkg::EV_HALF) | cb(asp_pkg::EV_OVR));
      wr(asp_pkg::OFF_CTRL, cb(0) | cb(asp_pkg::C_SCAN) | cb(asp_pkg::C_FAST));
      k = 0;
      do
      begin
         rdr(asp_pkg::OFF_STAT, d);
         `CHK(d[asp_pkg::EV_HALF], (d[15:6] >= 10'd256))
         k++;
      end
      while (d[asp_pkg::EV_OVR] !== 1'b1 && k < 4000);
      `CHK(irq, 1'b1)
      wr(asp_pkg::OFF_CTRL, 32'h0);
      repeat (60) @(posedge pclk);
      rdr(asp_pkg::OFF_STAT, d);
      `CHK(int'(d[15:6]), DEPTH)
      rdr(asp_pkg::OFF_FIFO, d);
      sq = d[11:4];
      for (k = 1; k < DEPTH; k++)
      begin
         rdr(asp_pkg::OFF_FIFO, d);
         `CHK(d[11:0], {sq + 8'(k), 4'h3})
      end
      rdr(asp_pkg::OFF_STAT, d);
      `CHK(d[3:0], 4'h8)
      wr(asp_pkg::OFF_IEN, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      wr(asp_pkg::OFF_STAT, cb(asp_pkg::EV_OVR));
      rdr(asp_pkg::OFF_STAT, d);
      `CHK(d[asp_pkg::EV_OVR], 1'b0)
   endtask : t_fill
   task automatic t_expand();
      wr(asp_pkg::OFF_DOUT, 32'h0000_000f);
      repeat (2) @(posedge pclk);
      `CHK(gp_out, 4'hf)
      wr(asp_pkg::OFF_CHAN, 32'h0000_0035);
      wr(asp_pkg::OFF_CTRL, cb(asp_pkg::C_EXPAND) | cb(asp_pkg::C_SWCONV));
      repeat (60) @(posedge pclk);
      `CHK(expansion_select_out, 4'h3)
      `CHK(gp_out, 4'h0)
      `CHK(mux_addr, 4'h5)
      wr(asp_pkg::OFF_CTRL, cb(asp_pkg::C_EXPAND) | cb(asp_pkg::C_DIFF));
      rdr(asp_pkg::OFF_CTRL, d);
      `CHK(d[asp_pkg::C_EXPAND], 1'b0)
      stop_drain();
   endtask : t_expand
   task automatic give_verdict();
      if (num_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Hang guard well above the longest expected run
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      ext_pacer_in = 1'b1;
      ext_trigger_in = 1'b1;
      extra = 8'h00;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_single();
      t_scan_wrap();
      t_pace();
      t_ext_trig();
      t_fill();
      t_expand();
      give_verdict();
   end
endmodule : tb_adc_scan_pacer_sequencer
